// ==== core/ris_bus_cycle.sv ====
// External bus cycle engine: address phase, strobed data phase, ready wait
`timescale 1ns/1ps
module ris_bus_cycle (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic go,
  input wire logic we,
  input wire logic io,
  input wire logic cfg_sel,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ready_pin,
  input wire logic [15:0] din_pin,
  output logic ack,
  output logic [15:0] rdata,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_dout,
  output logic bus_doe_n,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic bus_io_n,
  output logic bus_ds_n,
  output logic bus_as,
  output logic cfg_strobe_n
);
  import ris_pkg::*;
  ris_bph_t ph, next_ph;
  logic rdy_m, rdy_s, we_q, cfg_q;
  logic [15:0] din_m, din_s;
  wire take = go && (ph == BPH_IDLE);
  wire fin = (ph == BPH_DATA) && rdy_s;
  wire in_data = (next_ph == BPH_DATA);

  always_comb begin
    case (ph)
      BPH_IDLE: next_ph = go ? BPH_ADDR : BPH_IDLE;
      BPH_ADDR: next_ph = BPH_DATA;
      BPH_DATA: next_ph = rdy_s ? BPH_IDLE : BPH_DATA;
      default: next_ph = BPH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {rdy_m, rdy_s, din_m, din_s} <= '0;
      ph <= BPH_IDLE;
    end else begin
      rdy_m <= ready_pin;
      rdy_s <= rdy_m;
      din_m <= din_pin;
      din_s <= din_m;
      ph <= next_ph;
    end
  end

  // Standard strobes on every external step, none when idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {ack, rdata, bus_addr, bus_dout, we_q, cfg_q, bus_as} <= '0;
      {bus_doe_n, bus_rd_n, bus_wr_n, bus_io_n, bus_ds_n, cfg_strobe_n} <= '1;
    end else begin
      ack <= fin; // R17
      if (fin) begin
        rdata <= din_s;
      end
      if (take) begin
        bus_addr <= addr;
        bus_dout <= wdata;
        bus_io_n <= !io;
        we_q <= we;
        cfg_q <= cfg_sel && io && !we;
      end
      bus_as <= (next_ph == BPH_ADDR); // R17
      bus_rd_n <= !(in_data && !we_q);
      bus_wr_n <= !(in_data && we_q);
      bus_ds_n <= !in_data;
      bus_doe_n <= !(in_data && we_q);
      cfg_strobe_n <= !(in_data && cfg_q); // R2
    end
  end

  property p_cfg_strobe;
    @(posedge mclk) disable iff (!nrst)
      !cfg_strobe_n |-> (!bus_io_n && bus_wr_n && !bus_rd_n && bus_addr == CFG_IO_ADDR);
  endproperty
  a_cfg_strobe: assert property (p_cfg_strobe) else $error("config strobe outside read"); // R2

  property p_strobe_pair;
    @(posedge mclk) disable iff (!nrst)
      $fell(bus_ds_n) |-> $past(bus_as) && (bus_rd_n != bus_wr_n);
  endproperty
  a_strobe_pair: assert property (p_strobe_pair) else $error("data strobe without address"); // R17
endmodule // ris_bus_cycle

// ==== core/ris_pkg.sv ====
// Constants, types and decode functions of the reset initialisation sequencer
package ris_pkg;
  // ****************************************
  // External bus addresses and data words
  // ****************************************
  localparam logic [15:0] CFG_IO_ADDR = 16'h8410;
  localparam logic [15:0] MCR_IO_ADDR = 16'h0400;
  localparam logic [15:0] IPR_IO_BASE = 16'h8000;
  localparam logic [15:0] OPR_IO_BASE = 16'h8100;
  localparam logic [15:0] BPR_IO_BASE = 16'h8200;
  localparam logic [15:0] SW_IO_ADDR = 16'h8300;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] ONES_WORD = 16'hffff;
  // ****************************************
  // Loop counts
  // ****************************************
  localparam logic signed [9:0] BP_COUNT = 10'sh080;
  localparam logic signed [9:0] MMU_COUNT = 10'sh100;
  localparam logic signed [9:0] MCR_COUNT = 10'sh010;
  localparam logic signed [9:0] N_ONE = 10'sh001;
  localparam logic signed [9:0] N_ZERO = 10'sh000;
  // ****************************************
  // Configuration word and fault bits
  // ****************************************
  localparam int CB_MMU0 = 0;
  localparam int CB_BPU0 = 1;
  localparam int CB_MMU1 = 3;
  localparam int CB_MMU2 = 5;
  localparam int CB_BIT = 7;
  localparam int CB_SUR = 8;
  localparam int CB_MODE_A = 10;
  localparam int CB_BPU1 = 12;
  localparam int CB_BPU2 = 13;
  localparam int FT_BIT_FAIL = 13;
  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [4:0] A_STATUS = 5'h00;
  localparam logic [4:0] A_CONFIG = 5'h04;
  localparam logic [4:0] A_FAULT = 5'h08;
  localparam logic [4:0] A_FMASK = 5'h0c;
  localparam logic [4:0] A_FETCH0 = 5'h10;
  localparam logic [4:0] A_FETCH1 = 5'h14;
  localparam logic [4:0] A_CONTROL = 5'h18;
  localparam int CTL_RESTART = 0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    S_PIC_INIT, S_RD_CFG, S_BP_LOAD, S_BP_DEC, S_BP_CLR, S_WR_CFG, S_MMU_CHK,
    S_MMU_LOAD, S_MMU_DEC, S_MMU_IPR, S_MMU_OPR, S_MCR_LOAD, S_MCR_SEL, S_MCR_WR,
    S_MCR_DEC, S_IC_CLR, S_BIT_CHK, S_BIT_RUN, S_PIC_REINIT, S_SW_ZERO, S_FT_CHK,
    S_FT_SET, S_DISC, S_FETCH0, S_FETCH1, S_RUN
  } ris_state_t;
  typedef enum logic [1:0] {BPH_IDLE, BPH_ADDR, BPH_DATA} ris_bph_t;

  function automatic logic ris_mmu_fitted(input logic [15:0] cfg);
    ris_mmu_fitted = cfg[CB_MMU0] | cfg[CB_MMU1] | cfg[CB_MMU2];
  endfunction

  function automatic logic ris_bpu_fitted(input logic [15:0] cfg);
    ris_bpu_fitted = cfg[CB_BPU0] | cfg[CB_BPU1] | cfg[CB_BPU2];
  endfunction
endpackage

// ==== core/ris_sequencer.sv ====
// Power-up and reset initialisation sequencer with Avalon-MM status registers
// Summary of operation
// R1 - Fixed initialisation sequence before any instruction
// R2 - Read config word at 8410 with strobe low
// R3 - Protect-clear loop of 128, or 0 without unit
// R4 - Copy external config into internal register
// R5 - 256 instruction/operand page writes when unit fitted
// R6 - Page fields zero, physical page equals logical
// R7 - Seventeen memory control writes, one per bank; the code makes them only when the MMU is fitted
// R8 - Clear counter, self-test only when requested
// R9 - Self-test fail merges result, sets fault bit 13
// R10 - DMA disabled, start-up ROM enabled, pass flag
// R11 - Fetch words 0 and 1 with bank zero
// R12 - Execution starts after pipeline, pass or fail
// R13 - Status, fault, interrupt state left zero
// R14 - Extended mode sets fault mask all ones
// R15 - Timers and trigger-go run, trigger line high
// R16 - Reinitialise interrupt unit, zero status word
// R17 - External steps use normal strobed bus cycles
// R18 - System supplies 16-bit configuration word
// R19 - Pass flag high on pass or no self-test
// R20 - Config strobe enables the external latch
`timescale 1ns/1ps
module ris_sequencer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bus_ready,
  input wire logic [15:0] bus_din,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_dout,
  output logic bus_doe_n,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic bus_io_n,
  output logic bus_ds_n,
  output logic bus_as,
  output logic config_latch_read_strobe_n,
  output logic [4:0] page_bank,
  input wire logic selftest_done,
  input wire logic [15:0] selftest_result,
  output logic selftest_start,
  output logic int_unit_reset,
  output logic dma_enable_line,
  output logic startup_rom_enable,
  output logic selftest_pass_flag,
  output logic trigger_go_output,
  output logic timers_run,
  output logic exec_start
);
  import ris_pkg::*;
  // ****************************************
  // Sequencer state
  // ****************************************
  ris_state_t state, next_state;
  logic signed [9:0] n, next_n;
  logic pend, ack, st_fail, restart_req;
  logic [15:0] cfg_ext, cfg_int, fault, fmask, ic, st_res, word0, word1, rdata;
  wire logic signed [9:0] n_dec = n - N_ONE;
  wire block_protect_unit = ris_bpu_fitted(cfg_ext);
  wire mmu = ris_mmu_fitted(cfg_int);
  wire ext_step = (state == S_RD_CFG) || (state == S_BP_CLR) || (state == S_MMU_IPR)
    || (state == S_MMU_OPR) || (state == S_MCR_WR) || (state == S_SW_ZERO)
    || (state == S_FETCH0) || (state == S_FETCH1);
  wire go = ext_step && !pend;
  wire fetch = (state == S_FETCH0) || (state == S_FETCH1);
  wire req_we = !(state == S_RD_CFG) && !fetch;
  wire req_io = !fetch;
  wire req_cfg = (state == S_RD_CFG); // R2
  // Physical page equals the index, lock/write/exec fields stay clear
  wire [15:0] page_word = {8'h00, n[7:0]}; // R6
  wire [15:0] req_addr =
    (state == S_RD_CFG) ? CFG_IO_ADDR :
    (state == S_BP_CLR) ? (BPR_IO_BASE | page_word) :
    (state == S_MMU_IPR) ? (IPR_IO_BASE | page_word) :
    (state == S_MMU_OPR) ? (OPR_IO_BASE | page_word) :
    (state == S_MCR_WR) ? MCR_IO_ADDR :
    (state == S_SW_ZERO) ? SW_IO_ADDR :
    (state == S_FETCH1) ? (ic + 16'h0001) : ic; // R11
  wire [15:0] req_wdata =
    ((state == S_MMU_IPR) || (state == S_MMU_OPR)) ? page_word :
    (state == S_MCR_WR) ? {11'h000, page_bank} : ZERO_WORD;

  always_comb begin
    next_state = state;
    next_n = n;
    case (state)
      S_PIC_INIT: next_state = S_RD_CFG; // R1
      S_RD_CFG: if (ack) next_state = S_BP_LOAD;
      S_BP_LOAD: begin
        next_n = block_protect_unit ? BP_COUNT : N_ZERO; // R3
        next_state = S_BP_DEC;
      end
      S_BP_DEC: begin
        next_n = n_dec; // R3
        next_state = n_dec[9] ? S_WR_CFG : S_BP_CLR;
      end
      S_BP_CLR: if (ack) next_state = S_BP_DEC;
      S_WR_CFG: next_state = S_MMU_CHK;
      S_MMU_CHK: next_state = mmu ? S_MMU_LOAD : S_IC_CLR; // R5
      S_MMU_LOAD: begin
        next_n = MMU_COUNT; // R5
        next_state = S_MMU_DEC;
      end
      S_MMU_DEC: begin
        next_n = n_dec;
        next_state = S_MMU_IPR;
      end
      S_MMU_IPR: if (ack) next_state = S_MMU_OPR;
      S_MMU_OPR: if (ack) next_state = (n > N_ZERO) ? S_MMU_DEC : S_MCR_LOAD; // R5
      S_MCR_LOAD: begin
        next_n = MCR_COUNT; // R7
        next_state = S_MCR_SEL;
      end
      S_MCR_SEL: next_state = S_MCR_WR;
      S_MCR_WR: if (ack) next_state = S_MCR_DEC;
      S_MCR_DEC: begin
        next_n = n_dec;
        next_state = n_dec[9] ? S_IC_CLR : S_MCR_SEL; // R7
      end
      S_IC_CLR: next_state = S_BIT_CHK;
      S_BIT_CHK: next_state = cfg_int[CB_BIT] ? S_BIT_RUN : S_PIC_REINIT; // R8
      S_BIT_RUN: if (selftest_done) next_state = S_PIC_REINIT;
      S_PIC_REINIT: next_state = S_SW_ZERO;
      S_SW_ZERO: if (ack) next_state = S_FT_CHK;
      S_FT_CHK: next_state = st_fail ? S_FT_SET : S_DISC; // R9
      S_FT_SET: next_state = S_DISC;
      S_DISC: next_state = S_FETCH0;
      S_FETCH0: if (ack) next_state = S_FETCH1;
      S_FETCH1: if (ack) next_state = S_RUN; // R12
      S_RUN: if (restart_req) next_state = S_PIC_INIT;
      default: next_state = S_PIC_INIT;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= S_PIC_INIT;
      {n, pend} <= '0;
    end else begin
      state <= next_state;
      n <= next_n;
      pend <= go || (pend && !ack);
    end
  end

  // ****************************************
  // Configuration, counters and results
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {cfg_ext, cfg_int, ic, fault, fmask, st_res, st_fail, word0, word1} <= '0;
      page_bank <= '0;
    end else begin
      if (state == S_RD_CFG && ack) cfg_ext <= rdata; // R18
      if (state == S_WR_CFG) cfg_int <= cfg_ext; // R4
      if (state == S_MCR_SEL) page_bank <= n[4:0]; // R7
      if (state == S_DISC) page_bank <= '0; // R11
      if (state == S_IC_CLR) ic <= ZERO_WORD; // R8
      if (state == S_PIC_INIT) begin
        {fault, st_res, st_fail} <= '0; // R13
        fmask <= ZERO_WORD;
      end
      if (state == S_BIT_RUN && selftest_done) begin
        st_res <= selftest_result;
        st_fail <= |selftest_result;
      end
      if (state == S_FT_SET) begin
        fault <= fault | st_res; // R9
        fault[FT_BIT_FAIL] <= 1'b1; // R9
      end
      if (state == S_DISC) fmask <= cfg_int[CB_MODE_A] ? ZERO_WORD : ONES_WORD; // R14
      if (state == S_FETCH0 && ack) word0 <= rdata;
      if (state == S_FETCH1 && ack) word1 <= rdata;
    end
  end

  // ****************************************
  // Discrete outputs
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {selftest_start, int_unit_reset, dma_enable_line, startup_rom_enable} <= '0;
      {selftest_pass_flag, trigger_go_output, timers_run, exec_start} <= '0;
    end else begin
      selftest_start <= (state == S_BIT_CHK) && cfg_int[CB_BIT]; // R8
      int_unit_reset <= (state == S_PIC_INIT) || (state == S_PIC_REINIT); // R16
      if (state == S_PIC_INIT) begin
        {selftest_pass_flag, trigger_go_output, timers_run, exec_start} <= '0;
      end
      if (state == S_DISC) begin
        dma_enable_line <= 1'b0; // R10
        startup_rom_enable <= 1'b1; // R10
        selftest_pass_flag <= !st_fail; // R19
        trigger_go_output <= 1'b1; // R15
        timers_run <= 1'b1; // R15
      end
      if (state == S_FETCH1 && ack) exec_start <= 1'b1; // R12
    end
  end

  // ****************************************
  // Avalon-MM slave, one wait state per access
  // ****************************************
  wire req = avs_read || avs_write;
  wire [31:0] rd_mux =
    (avs_address == A_STATUS) ? {19'h00000, state, 4'h0, block_protect_unit, mmu,
      selftest_pass_flag, exec_start} :
    (avs_address == A_CONFIG) ? {16'h0000, cfg_int} :
    (avs_address == A_FAULT) ? {16'h0000, fault} :
    (avs_address == A_FMASK) ? {16'h0000, fmask} :
    (avs_address == A_FETCH0) ? {16'h0000, word0} :
    (avs_address == A_FETCH1) ? {16'h0000, word1} : 32'h00000000;
  wire ctl_wr = avs_write && !avs_waitrequest && (avs_address == A_CONTROL);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      restart_req <= 1'b0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) avs_readdata <= rd_mux;
      // A new request wins over the restart being consumed
      restart_req <= (ctl_wr && avs_writedata[CTL_RESTART]) || (restart_req && state != S_RUN);
    end
  end

  ris_bus_cycle u_bus (
    .mclk(mclk),
    .nrst(nrst),
    .go(go),
    .we(req_we),
    .io(req_io),
    .cfg_sel(req_cfg),
    .addr(req_addr),
    .wdata(req_wdata),
    .ready_pin(bus_ready),
    .din_pin(bus_din),
    .ack(ack),
    .rdata(rdata),
    .bus_addr(bus_addr),
    .bus_dout(bus_dout),
    .bus_doe_n(bus_doe_n),
    .bus_rd_n(bus_rd_n),
    .bus_wr_n(bus_wr_n),
    .bus_io_n(bus_io_n),
    .bus_ds_n(bus_ds_n),
    .bus_as(bus_as),
    .cfg_strobe_n(config_latch_read_strobe_n)
  );

  // ****************************************
  // Checks
  // ****************************************
  property p_bp_load;
    @(posedge mclk) disable iff (!nrst)
      state == S_BP_LOAD |=> n == ($past(block_protect_unit) ? BP_COUNT : N_ZERO);
  endproperty
  a_bp_load: assert property (p_bp_load) else $error("protect loop count wrong"); // R3

  property p_cfg_copy;
    @(posedge mclk) disable iff (!nrst) state == S_WR_CFG |=> cfg_int == $past(cfg_ext);
  endproperty
  a_cfg_copy: assert property (p_cfg_copy) else $error("internal config not loaded"); // R4

  property p_mmu_skip;
    @(posedge mclk) disable iff (!nrst) state == S_MMU_CHK && !mmu |=> state == S_IC_CLR;
  endproperty
  a_mmu_skip: assert property (p_mmu_skip) else $error("page load without unit"); // R5

  property p_page_word;
    @(posedge mclk) disable iff (!nrst)
      go && state == S_MMU_IPR |-> req_wdata[15:8] == 8'h00 && req_wdata[7:0] == n[7:0];
  endproperty
  a_page_word: assert property (p_page_word) else $error("page register not identity"); // R6

  property p_mcr_load;
    @(posedge mclk) disable iff (!nrst) state == S_MCR_LOAD |=> n == MCR_COUNT;
  endproperty
  a_mcr_load: assert property (p_mcr_load) else $error("bank count wrong"); // R7

  property p_bit_skip;
    @(posedge mclk) disable iff (!nrst)
      state == S_BIT_CHK && !cfg_int[CB_BIT] |=> state == S_PIC_REINIT ##1 !selftest_start;
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("self-test run unrequested"); // R8

  property p_ft_set;
    @(posedge mclk) disable iff (!nrst) state == S_FT_SET |=> fault[FT_BIT_FAIL];
  endproperty
  a_ft_set: assert property (p_ft_set) else $error("fault bit not set"); // R9

  property p_disc;
    @(posedge mclk) disable iff (!nrst)
      state == S_DISC |=> !dma_enable_line && startup_rom_enable && trigger_go_output
        && selftest_pass_flag == !$past(st_fail);
  endproperty
  a_disc: assert property (p_disc) else $error("discretes not initialised"); // R10

  property p_fetch;
    @(posedge mclk) disable iff (!nrst)
      go && fetch |-> !req_io && page_bank == 5'h00 && req_addr[15:1] == 15'h0000;
  endproperty
  a_fetch: assert property (p_fetch) else $error("pipeline fetch misaddressed"); // R11

  property p_exec;
    @(posedge mclk) disable iff (!nrst) state == S_FETCH1 && ack |=> ##1 exec_start;
  endproperty
  a_exec: assert property (p_exec) else $error("execution not started"); // R12
endmodule // ris_sequencer

// ==== test/ris_far_model.sv ====
// Far-side model: configuration latch, page and protect units, start-up ROM
`timescale 1ns/1ps
module ris_far_model
  import ris_pkg::*;
#(
  parameter logic [15:0] ROM0 = 16'h3c5a,
  parameter logic [15:0] ROM1 = 16'hc3a5
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic slow,
  input wire logic [15:0] cfg_word,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_dout,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic bus_io_n,
  input wire logic bus_ds_n,
  input wire logic config_latch_read_strobe_n,
  input wire logic [4:0] page_bank,
  output logic bus_ready,
  output logic [15:0] bus_din,
  output int n_cfg,
  output int n_bp,
  output int n_pg,
  output int n_mcr,
  output int n_sw,
  output int n_mem,
  output int n_bad
);
  int wait_cnt;
  logic [15:0] rd_word;
  logic io_wr;
  // Latch drives only under its own strobe, so a missing strobe shows up
  assign rd_word = !config_latch_read_strobe_n ? cfg_word : (bus_addr == 16'h0001 ? ROM1 : ROM0);
  assign io_wr = !bus_wr_n && !bus_io_n;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_ready <= 1'b0;
      bus_din <= 16'ha5a5;
      wait_cnt <= 0;
    end else if (bus_ds_n) begin
      bus_ready <= 1'b0;
      wait_cnt <= 0;
      // Released bus never keeps the last word
      bus_din <= ~bus_din;
    end else begin
      if (wait_cnt >= (slow ? 4 : 0)) begin
        bus_ready <= 1'b1;
        if (!bus_ready) bus_din <= rd_word;
      end
      wait_cnt <= wait_cnt + 1;
    end
  end
  always @(posedge mclk) begin
    if (clr) begin
      n_cfg <= 0;
      n_bp <= 0;
      n_pg <= 0;
      n_mcr <= 0;
      n_sw <= 0;
      n_mem <= 0;
      n_bad <= 0;
    end else if (!bus_ds_n && wait_cnt == 0) begin
      if (!config_latch_read_strobe_n) begin
        n_cfg <= n_cfg + 1;
        if (bus_io_n || bus_rd_n || bus_addr != CFG_IO_ADDR) n_bad <= n_bad + 1;
      end else if (io_wr && bus_addr[15:8] == 8'h82) begin
        n_bp <= n_bp + 1;
        if (bus_dout != ZERO_WORD) n_bad <= n_bad + 1;
      end else if (io_wr && bus_addr[15:9] == 7'h40) begin
        n_pg <= n_pg + 1;
        if (bus_dout != {8'h00, bus_addr[7:0]}) n_bad <= n_bad + 1;
      end else if (io_wr && bus_addr == MCR_IO_ADDR) begin
        n_mcr <= n_mcr + 1;
        if (bus_dout[4:0] != page_bank) n_bad <= n_bad + 1;
      end else if (io_wr && bus_addr == SW_IO_ADDR) begin
        n_sw <= n_sw + 1;
        if (bus_dout != ZERO_WORD) n_bad <= n_bad + 1;
      end else if (!bus_rd_n && bus_io_n && page_bank == 5'h0 && bus_addr <= 16'h0001) begin
        n_mem <= n_mem + 1;
      end else begin
        n_bad <= n_bad + 1;
      end
    end
  end
endmodule // ris_far_model

// ==== test/testbench.sv ====
// Self-checking bench of the reset initialisation sequencer
`timescale 1ns/1ps
module testbench;
  import ris_pkg::*;
  localparam logic [15:0] ROM0 = 16'h3c5a;
  localparam logic [15:0] ROM1 = 16'hc3a5;
  logic mclk, nrst, avs_read, avs_write, avs_waitrequest, bus_ready, clr, slow;
  logic bus_doe_n, bus_rd_n, bus_wr_n, bus_io_n, bus_ds_n, bus_as, config_latch_read_strobe_n;
  logic selftest_done, selftest_start, int_unit_reset, dma_enable_line, startup_rom_enable;
  logic selftest_pass_flag, trigger_go_output, timers_run, exec_start;
  logic [4:0] avs_address, page_bank;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] bus_din, bus_addr, bus_dout, selftest_result, cfg_word;
  int n_cfg, n_bp, n_pg, n_mcr, n_sw, n_mem, n_bad, n_st, st_cnt, error_cnt, n_checks, cycles;
  int n_pic, n_as, n_oe;
  ris_sequencer u_dut (.mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .bus_ready, .bus_din, .bus_addr, .bus_dout, .bus_doe_n,
    .bus_rd_n, .bus_wr_n, .bus_io_n, .bus_ds_n, .bus_as, .config_latch_read_strobe_n,
    .page_bank, .selftest_done, .selftest_result, .selftest_start, .int_unit_reset,
    .dma_enable_line, .startup_rom_enable, .selftest_pass_flag, .trigger_go_output,
    .timers_run, .exec_start);
  ris_far_model #(.ROM0(ROM0), .ROM1(ROM1)) u_far (.mclk, .nrst, .clr, .slow, .cfg_word,
    .bus_addr, .bus_dout, .bus_rd_n, .bus_wr_n, .bus_io_n, .bus_ds_n,
    .config_latch_read_strobe_n, .page_bank, .bus_ready, .bus_din, .n_cfg, .n_bp, .n_pg,
    .n_mcr, .n_sw, .n_mem, .n_bad);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ****************************************
  // Timeout and self-test responder
  // ****************************************
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      results();
    end
  end
  always @(posedge mclk) begin
    selftest_done <= (st_cnt == 1);
    if (clr) begin
      n_st <= 0;
      n_pic <= 0;
      n_as <= 0;
      n_oe <= 0;
    end else begin
      if (selftest_start === 1'b1) n_st <= n_st + 1;
      if (int_unit_reset === 1'b1) n_pic <= n_pic + 1;
      if (bus_as === 1'b1) n_as <= n_as + 1;
      // Data bus driven exactly while writing
      if (bus_doe_n !== bus_wr_n) n_oe <= n_oe + 1;
    end
    if (selftest_start === 1'b1) st_cnt <= 6;
    else if (st_cnt > 0) st_cnt <= st_cnt - 1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic av_read(input logic [4:0] a);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic av_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input string what, input logic [31:0] exp);
    av_read(a);
    check(what, rd, exp);
  endtask
  // One whole sequence with a given configuration word, then its end state
  task automatic run(input logic [15:0] cfg, input logic fail, input logic sl, input logic mid);
    logic bp, mm, st, pass;
    bp = cfg[CB_BPU0] | cfg[CB_BPU1] | cfg[CB_BPU2];
    mm = cfg[CB_MMU0] | cfg[CB_MMU1] | cfg[CB_MMU2];
    st = cfg[CB_BIT];
    pass = !(st && fail);
    cfg_word <= cfg;
    slow <= sl;
    selftest_result <= fail ? 16'h0480 : 16'h0000;
    if (exec_start === 1'b1) begin
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      av_write(A_CONTROL, 32'h1);
      while (exec_start === 1'b1) @(posedge mclk);
    end
    if (mid) begin
      repeat (40) @(posedge mclk);
      nrst <= 1'b0;
      clr <= 1'b1;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      clr <= 1'b0;
    end
    while (exec_start !== 1'b1) @(posedge mclk);
    check("config reads", n_cfg, 1);
    check("protect writes", n_bp, bp ? 128 : 0);
    check("page writes", n_pg, mm ? 512 : 0);
    check("control writes", n_mcr, mm ? 17 : 0);
    check("status word writes", n_sw, 1);
    check("fetches", n_mem, 2);
    check("bad bus cycles", n_bad, 0);
    check("selftest starts", n_st, {31'h0, st});
    check("interrupt unit resets", n_pic, 2);
    check("address phases", n_as, 4 + (bp ? 128 : 0) + (mm ? 529 : 0));
    check("data drive", n_oe, 0);
    rd_chk(A_CONFIG, "config", {16'h0, cfg});
    rd_chk(A_FAULT, "fault", pass ? 32'h0 : 32'h2480);
    rd_chk(A_FMASK, "fault mask", cfg[CB_MODE_A] ? 32'h0 : 32'hffff);
    rd_chk(A_FETCH0, "word 0", {16'h0, ROM0});
    rd_chk(A_FETCH1, "word 1", {16'h0, ROM1});
    av_read(A_STATUS);
    check("status", rd & 32'h1f0f, {19'h0, 5'd25, 4'h0, bp, mm, pass, 1'b1});
    check("discretes", {dma_enable_line, startup_rom_enable, trigger_go_output, timers_run,
      selftest_pass_flag, page_bank}, {4'b0111, pass, 5'h0});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    clr = 1'b1;
    slow = 1'b0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cfg_word = 16'h0000;
    selftest_result = 16'h0;
    selftest_done = 1'b0;
    st_cnt = 0;
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    clr <= 1'b0;
    run(16'h0000, 1'b0, 1'b0, 1'b0);
    av_write(A_CONFIG, 32'hffff);
    rd_chk(5'h1c, "unmapped", 32'h0);
    rd_chk(A_CONFIG, "config kept", 32'h0);
    run(16'h0403, 1'b0, 1'b1, 1'b0);
    run(16'h31a8, 1'b1, 1'b1, 1'b1);
    run(16'h0480, 1'b0, 1'b0, 1'b0);
    results();
  end
endmodule // testbench
